// ---- rtl/port_mux_pkg.sv ----
`default_nettype none
package port_mux_pkg;
  localparam int PORT_W = 8;
  localparam int NIB_W = 4;
  localparam int UP_LO = 2;
  localparam int UP_HI = 7;
  localparam int NMI_BIT = 0;
  localparam int IRQ_A_BIT = 1;
  localparam int CSI1_BIT = 5;
  localparam int IRQ_F_BIT = 6;
  localparam int D_CLK_BIT = 2;
  localparam int D_DAT_BIT = 3;
  localparam int K_CLK_BIT = 5;
  localparam int K_DAT_BIT = 7;
  localparam int B_BAUD_BIT = 2;
  localparam int B_RX_BIT = 3;
  localparam int B_TX_BIT = 4;
  localparam int HOLD_REQ_BIT = 6;
  localparam int HOLD_ACK_BIT = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SYNC = 2'h0;

  // one bidirectional pin group as seen by the core
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull;
  } pin_drive_t;

  // settings for a plain i/o port
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir_in;
    logic pull_en;
  } port_cfg_t;

  typedef enum logic [1:0] {
    P7_FN_PORT = 2'h0,
    P7_FN_HOLD = 2'h1,
    P7_FN_WAIT = 2'h2
  } bus_ctl_fn_t;
endpackage : port_mux_pkg
`default_nettype wire

// ---- rtl/port_pin_function_mux.sv ----
// Contract
// - port_a is eight bits, per-bit direction, also a 2x4 real-time output.
// - one pull-up enable per port acts on every pin of it currently acting as input, on input_only_port bits 2..7 only; analog_shared_port has none.
// - input_only_port is input only except bit 5; bit 0 feeds only the nmi but stays readable.
// - input_only_port pull-ups cover bits 2..7 under one enable.
// - input_only_port bit 5 is csi_one_clock i/o if csi_one_mode_reg selects.
// - port_d bits 2 and 3 may each be n-channel open drain.
// - port_k bits 5 and 7 may each be n-channel open drain.
// - analog_shared_port has per-bit direction and feeds analog_inputs.
// - second port bits 2..4 carry uart_b and csi two clock and data.
// - ext_irq_in_a also clocks timer 1 and triggers tc1_capcmp_a/b.
// - ext_irq_in_f also starts an a/d conversion.
// - port g bits 6,7 carry bus_hold_req/ack or wait/refresh_pulse_out.
// - addr_latch_strobe shares its pin with clock_out_pin.
`default_nettype none
module port_pin_function_mux
  import port_mux_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // pins (input, output, output enable, pull-up request)
  input wire logic [7:0] PA_IN,
  output port_mux_pkg::pin_drive_t PA_PIN,
  input wire logic [7:0] PB_IN,
  output port_mux_pkg::pin_drive_t PB_PIN,
  input wire logic [7:0] IOP_IN,
  output logic [7:0] IOP_PULL,
  output logic IOP_CSI1_OUT,
  output logic IOP_CSI1_OE,
  input wire logic [7:0] PD_IN,
  output port_mux_pkg::pin_drive_t PD_PIN,
  input wire logic [7:0] PG_IN,
  output port_mux_pkg::pin_drive_t PG_PIN,
  input wire logic [7:0] PAN_IN,
  output port_mux_pkg::pin_drive_t PAN_PIN,
  input wire logic [7:0] PK_IN,
  output port_mux_pkg::pin_drive_t PK_PIN,
  output logic STROBE_CLK_PIN,
  // software settings
  input wire port_mux_pkg::port_cfg_t PA_CFG,
  input wire logic [1:0] PA_RTO_EN,
  input wire logic [7:0] PA_RTO_DATA,
  input wire port_mux_pkg::port_cfg_t PB_CFG,
  input wire logic PB_UART_B_EN,
  input wire logic PB_CSI2_EN,
  input wire logic IOP_PULL_EN,
  input wire logic CSI_ONE_MODE_REG,
  input wire port_mux_pkg::port_cfg_t PD_CFG,
  input wire logic [1:0] PD_OD_EN,
  input wire logic PD_CSI0_EN,
  input wire port_mux_pkg::port_cfg_t PG_CFG,
  input wire port_mux_pkg::bus_ctl_fn_t PG_FN,
  input wire port_mux_pkg::port_cfg_t PAN_CFG,
  input wire port_mux_pkg::port_cfg_t PK_CFG,
  input wire logic [1:0] PK_OD_EN,
  input wire logic PK_CSI3_EN,
  input wire logic STROBE_SEL_CLK,
  // peripheral side
  input wire logic CSI1_CLK_OUT,
  input wire logic CSI1_CLK_MASTER,
  input wire logic CSI0_CLK_OUT,
  input wire logic CSI0_DATA_OUT,
  input wire logic CSI3_CLK_OUT,
  input wire logic CSI3_DATA_OUT,
  input wire logic CSI2_CLK_OUT,
  input wire logic CSI2_CLK_MASTER,
  input wire logic CSI2_DATA_OUT,
  input wire logic UART_B_TX,
  input wire logic BUS_HOLD_ACK,
  input wire logic REFRESH_PULSE_OUT,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic CLOCK_OUT_PIN,
  // values seen by software and peripherals
  output logic [7:0] PA_RD,
  output logic [7:0] PB_RD,
  output logic [7:0] IOP_RD,
  output logic [7:0] PD_RD,
  output logic [7:0] PG_RD,
  output logic [7:0] PAN_RD,
  output logic [7:0] PK_RD,
  output logic [7:0] ANALOG_INPUTS,
  output logic NMI_REQ,
  output logic EXT_IRQ_IN_A,
  output logic TC1_COUNT_CLK,
  output logic TC1_CAPCMP_A_TRIG,
  output logic TC1_CAPCMP_B_TRIG,
  output logic EXT_IRQ_IN_F,
  output logic AD_START_TRIG,
  output logic CSI_ONE_CLOCK_IN,
  output logic UART_B_RX,
  output logic UART_B_BAUD_CLK,
  output logic CSI2_DATA_IN,
  output logic CSI2_CLK_IN,
  output logic BUS_HOLD_REQ,
  output logic WAIT_REQ
);
  import port_mux_pkg::*;

  // every pin input crosses two flip-flops before use
  logic [7:0] pa_m_q, pa_s_q, pb_m_q, pb_s_q, iop_m_q, iop_s_q;
  logic [7:0] pd_m_q, pd_s_q, pg_m_q, pg_s_q, pan_m_q, pan_s_q;
  logic [7:0] pk_m_q, pk_s_q;

  // reset empties the history so every read starts at zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pa_m_q <= RST_BYTE;
      pa_s_q <= RST_BYTE;
      pb_m_q <= RST_BYTE;
      pb_s_q <= RST_BYTE;
      iop_m_q <= RST_BYTE;
      iop_s_q <= RST_BYTE;
      pd_m_q <= RST_BYTE;
      pd_s_q <= RST_BYTE;
      pg_m_q <= RST_BYTE;
      pg_s_q <= RST_BYTE;
      pan_m_q <= RST_BYTE;
      pan_s_q <= RST_BYTE;
      pk_m_q <= RST_BYTE;
      pk_s_q <= RST_BYTE;
    end else begin
      pa_m_q <= PA_IN;
      pa_s_q <= pa_m_q;
      pb_m_q <= PB_IN;
      pb_s_q <= pb_m_q;
      iop_m_q <= IOP_IN;
      iop_s_q <= iop_m_q;
      pd_m_q <= PD_IN;
      pd_s_q <= pd_m_q;
      pg_m_q <= PG_IN;
      pg_s_q <= pg_m_q;
      pan_m_q <= PAN_IN;
      pan_s_q <= pan_m_q;
      pk_m_q <= PK_IN;
      pk_s_q <= pk_m_q;
    end
  end

  // port_a: real-time groups override the latch per nibble
  wire [7:0] pa_rto_mask = {{NIB_W{PA_RTO_EN[1]}}, {NIB_W{PA_RTO_EN[0]}}};
  wire [7:0] pa_out = (PA_RTO_DATA & pa_rto_mask)
                    | (PA_CFG.latch & ~pa_rto_mask);
  // a real-time nibble always drives, whatever its direction bits say
  wire [7:0] pa_oe = ~PA_CFG.dir_in | pa_rto_mask;

  // second i/o port: uart_b and csi two alternates
  wire pb_alt = PB_UART_B_EN | PB_CSI2_EN;
  wire pb_clk_drv = PB_CSI2_EN & CSI2_CLK_MASTER;
  // csi two wins the shared tx pin when both alternates are on
  wire pb_tx = PB_CSI2_EN ? CSI2_DATA_OUT : UART_B_TX;
  logic [7:0] pb_out, pb_oe;
  always_comb begin
    pb_out = PB_CFG.latch;
    pb_oe = ~PB_CFG.dir_in;
    if (pb_alt) begin
      pb_out[B_TX_BIT] = pb_tx;
      pb_oe[B_TX_BIT] = 1'b1;
      // the receive pin stays an input whatever dir_in says
      pb_oe[B_RX_BIT] = 1'b0;
      pb_out[B_BAUD_BIT] = CSI2_CLK_OUT;
      pb_oe[B_BAUD_BIT] = pb_clk_drv;
    end
  end

  // port_d: csi zero clock/data with optional open drain
  logic [7:0] pd_out, pd_oe;
  always_comb begin
    pd_out = PD_CFG.latch;
    pd_oe = ~PD_CFG.dir_in;
    // the serial channel takes both pins regardless of direction
    if (PD_CSI0_EN) begin
      pd_out[D_CLK_BIT] = CSI0_CLK_OUT;
      pd_out[D_DAT_BIT] = CSI0_DATA_OUT;
      pd_oe[D_CLK_BIT] = 1'b1;
      pd_oe[D_DAT_BIT] = 1'b1;
    end
    // open drain drives only the low level
    if (PD_OD_EN[0]) begin
      pd_oe[D_CLK_BIT] = pd_oe[D_CLK_BIT] & ~pd_out[D_CLK_BIT];
      pd_out[D_CLK_BIT] = 1'b0;
    end
    if (PD_OD_EN[1]) begin
      pd_oe[D_DAT_BIT] = pd_oe[D_DAT_BIT] & ~pd_out[D_DAT_BIT];
      pd_out[D_DAT_BIT] = 1'b0;
    end
  end

  // port_k: csi three clock/data with optional open drain
  logic [7:0] pk_out, pk_oe;
  always_comb begin
    pk_out = PK_CFG.latch;
    pk_oe = ~PK_CFG.dir_in;
    if (PK_CSI3_EN) begin
      pk_out[K_CLK_BIT] = CSI3_CLK_OUT;
      pk_out[K_DAT_BIT] = CSI3_DATA_OUT;
      pk_oe[K_CLK_BIT] = 1'b1;
      pk_oe[K_DAT_BIT] = 1'b1;
    end
    // as on port_d, open drain only ever pulls low
    if (PK_OD_EN[0]) begin
      pk_oe[K_CLK_BIT] = pk_oe[K_CLK_BIT] & ~pk_out[K_CLK_BIT];
      pk_out[K_CLK_BIT] = 1'b0;
    end
    if (PK_OD_EN[1]) begin
      pk_oe[K_DAT_BIT] = pk_oe[K_DAT_BIT] & ~pk_out[K_DAT_BIT];
      pk_out[K_DAT_BIT] = 1'b0;
    end
  end

  // port g: bus hold pair or wait/refresh pair on bits 6 and 7
  logic [7:0] pg_out, pg_oe;
  always_comb begin
    pg_out = PG_CFG.latch;
    pg_oe = ~PG_CFG.dir_in;
    // code 3 is unused and leaves the port pins alone
    unique case (PG_FN)
      P7_FN_HOLD: begin
        pg_oe[HOLD_REQ_BIT] = 1'b0;
        pg_out[HOLD_ACK_BIT] = BUS_HOLD_ACK;
        pg_oe[HOLD_ACK_BIT] = 1'b1;
      end
      P7_FN_WAIT: begin
        pg_oe[HOLD_REQ_BIT] = 1'b0;
        pg_out[HOLD_ACK_BIT] = REFRESH_PULSE_OUT;
        pg_oe[HOLD_ACK_BIT] = 1'b1;
      end
      P7_FN_PORT: begin
      end
      default: begin
      end
    endcase
  end
  // bit 6 is an input in both bus modes; its meaning follows PG_FN
  wire pg_hold = (PG_FN == P7_FN_HOLD);
  wire pg_wait = (PG_FN == P7_FN_WAIT);

  // pull-ups only on pins currently acting as inputs
  wire [7:0] pa_pull = {PORT_W{PA_CFG.pull_en}} & ~pa_oe;
  wire [7:0] pb_pull = {PORT_W{PB_CFG.pull_en}} & ~pb_oe;
  wire [7:0] pd_pull = {PORT_W{PD_CFG.pull_en}} & ~pd_oe;
  wire [7:0] pg_pull = {PORT_W{PG_CFG.pull_en}} & ~pg_oe;
  wire [7:0] pk_pull = {PORT_W{PK_CFG.pull_en}} & ~pk_oe;
  // analog port has no pull-ups so the a/d sees the raw level
  wire [7:0] pan_oe = ~PAN_CFG.dir_in;

  // input-only port: csi one clock is the sole driver
  wire csi1_drv = CSI_ONE_MODE_REG & CSI1_CLK_MASTER;
  // one enable spans the six pins above the nmi and irq a inputs
  wire [UP_HI-UP_LO:0] iop_pull_grp = {(UP_HI - UP_LO + 1){IOP_PULL_EN}};
  logic [7:0] iop_pull;
  always_comb begin
    iop_pull = RST_BYTE;
    iop_pull[UP_HI:UP_LO] = iop_pull_grp;
    // a driving pin must not also be pulled up
    iop_pull[CSI1_BIT] = iop_pull[CSI1_BIT] & ~csi1_drv;
  end

  assign PA_PIN = '{dout: pa_out, oe: pa_oe, pull: pa_pull};
  assign PB_PIN = '{dout: pb_out, oe: pb_oe, pull: pb_pull};
  assign PD_PIN = '{dout: pd_out, oe: pd_oe, pull: pd_pull};
  assign PG_PIN = '{dout: pg_out, oe: pg_oe, pull: pg_pull};
  assign PK_PIN = '{dout: pk_out, oe: pk_oe, pull: pk_pull};
  assign PAN_PIN = '{dout: PAN_CFG.latch, oe: pan_oe, pull: RST_BYTE};
  assign IOP_PULL = iop_pull;
  assign IOP_CSI1_OUT = CSI1_CLK_OUT;
  assign IOP_CSI1_OE = csi1_drv;
  // strobe pin carries either the address strobe or the clock output
  assign STROBE_CLK_PIN = STROBE_SEL_CLK ? CLOCK_OUT_PIN
                                         : ADDR_LATCH_STROBE;

  // input paths always show the synchronised pin level
  assign PA_RD = pa_s_q;
  assign PB_RD = pb_s_q;
  assign IOP_RD = iop_s_q;
  assign PD_RD = pd_s_q;
  assign PG_RD = pg_s_q;
  assign PAN_RD = pan_s_q;
  assign PK_RD = pk_s_q;
  assign ANALOG_INPUTS = pan_s_q;

  // raw levels only; edge handling stays in each consumer
  assign NMI_REQ = iop_s_q[NMI_BIT];
  assign EXT_IRQ_IN_A = iop_s_q[IRQ_A_BIT];
  assign TC1_COUNT_CLK = iop_s_q[IRQ_A_BIT];
  assign TC1_CAPCMP_A_TRIG = iop_s_q[IRQ_A_BIT];
  assign TC1_CAPCMP_B_TRIG = iop_s_q[IRQ_A_BIT];
  assign EXT_IRQ_IN_F = iop_s_q[IRQ_F_BIT];
  assign AD_START_TRIG = iop_s_q[IRQ_F_BIT];
  assign CSI_ONE_CLOCK_IN = iop_s_q[CSI1_BIT];
  // uart_b and csi two share one receive pin and one clock pin
  assign UART_B_RX = pb_s_q[B_RX_BIT];
  assign CSI2_DATA_IN = pb_s_q[B_RX_BIT];
  assign UART_B_BAUD_CLK = pb_s_q[B_BAUD_BIT];
  assign CSI2_CLK_IN = pb_s_q[B_BAUD_BIT];
  // alternates read as inactive when not selected
  assign BUS_HOLD_REQ = pg_hold & pg_s_q[HOLD_REQ_BIT];
  assign WAIT_REQ = pg_wait & pg_s_q[HOLD_REQ_BIT];
endmodule : port_pin_function_mux
`default_nettype wire

// ---- verification/pad_world.sv ----
`default_nettype none
module pad_world
  import port_mux_pkg::*;
(
  // pad drive from the port
  input wire port_mux_pkg::pin_drive_t p,
  // external circuit
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // a floating pin reads high when pulled up, else the inverse of the latch
  assign lvl = (p.oe & p.dout) | (~p.oe & ext_en & ext)
    | (~p.oe & ~ext_en & (p.pull | ~p.dout));
endmodule : pad_world
`default_nettype wire

// ---- verification/port_mux_sva.sv ----
`default_nettype none
module port_mux_sva
  import port_mux_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] IOP_IN,
  input wire logic [7:0] PAN_IN,
  input wire logic [7:0] IOP_PULL,
  input wire logic IOP_PULL_EN,
  input wire logic [7:0] IOP_RD,
  input wire logic NMI_REQ,
  input wire logic EXT_IRQ_IN_A,
  input wire logic TC1_COUNT_CLK,
  input wire logic TC1_CAPCMP_A_TRIG,
  input wire logic TC1_CAPCMP_B_TRIG,
  input wire logic AD_START_TRIG,
  input wire logic [7:0] ANALOG_INPUTS,
  input wire logic IOP_CSI1_OE,
  input wire logic CSI_ONE_MODE_REG,
  input wire logic CSI1_CLK_MASTER,
  input wire port_mux_pkg::pin_drive_t PD_PIN,
  input wire logic [1:0] PD_OD_EN,
  input wire logic PD_CSI0_EN,
  input wire logic CSI0_CLK_OUT,
  input wire port_mux_pkg::pin_drive_t PK_PIN,
  input wire logic [1:0] PK_OD_EN,
  input wire logic PK_CSI3_EN,
  input wire logic CSI3_DATA_OUT,
  input wire logic STROBE_CLK_PIN,
  input wire logic STROBE_SEL_CLK,
  input wire logic CLOCK_OUT_PIN,
  input wire logic ADDR_LATCH_STROBE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_q;
  // synchroniser history is stale until three edges after reset
  always_ff @(posedge CORE_CLK)
    if (!RST_N) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_nmi_level: assert property (
    up_q == 2'h3 |-> NMI_REQ == $past(IOP_IN[0], 2) && IOP_RD[0] == NMI_REQ)
    else $error("nmi path wrong");
  a_irq_fanout: assert property (
    up_q == 2'h3 |-> EXT_IRQ_IN_A == $past(IOP_IN[1], 2) &&
    {TC1_COUNT_CLK, TC1_CAPCMP_A_TRIG, TC1_CAPCMP_B_TRIG} ==
    {3{EXT_IRQ_IN_A}}) else $error("timer 1 inputs wrong");
  a_ad_trigger: assert property (
    up_q == 2'h3 |-> AD_START_TRIG == $past(IOP_IN[6], 2))
    else $error("conversion trigger wrong");
  a_analog_path: assert property (
    up_q == 2'h3 |-> ANALOG_INPUTS == $past(PAN_IN, 2))
    else $error("analog inputs wrong");
  a_iop_pulls: assert property (
    IOP_PULL[1:0] == 2'h0 &&
    {IOP_PULL[7:6], IOP_PULL[4:2]} == {5{IOP_PULL_EN}})
    else $error("input port pull-ups wrong");
  a_csi1_drive: assert property (
    IOP_CSI1_OE == (CSI_ONE_MODE_REG && CSI1_CLK_MASTER) &&
    !(IOP_CSI1_OE && IOP_PULL[5])) else $error("serial 1 clock drive wrong");
  a_pd_clk_od: assert property (
    PD_OD_EN[0] && PD_CSI0_EN |-> PD_PIN.oe[2] == !CSI0_CLK_OUT &&
    !(PD_PIN.oe[2] && PD_PIN.dout[2])) else $error("port d open drain wrong");
  a_pk_dat_od: assert property (
    PK_OD_EN[1] && PK_CSI3_EN |-> PK_PIN.oe[7] == !CSI3_DATA_OUT &&
    !(PK_PIN.oe[7] && PK_PIN.dout[7])) else $error("port k open drain wrong");
  a_strobe_pin: assert property (
    STROBE_CLK_PIN == (STROBE_SEL_CLK ? CLOCK_OUT_PIN : ADDR_LATCH_STROBE))
    else $error("strobe pin wrong");
endmodule : port_mux_sva
bind port_pin_function_mux port_mux_sva chk (.*);
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb
  import port_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] PA_IN, PB_IN, IOP_IN, PD_IN, PG_IN, PAN_IN, PK_IN, IOP_PULL;
  logic [7:0] PA_RTO_DATA, PA_RD, PB_RD, IOP_RD, PD_RD, PG_RD, PAN_RD, PK_RD;
  logic [7:0] ANALOG_INPUTS;
  logic [7:0] xt [6];
  logic [7:0] xe [6];
  pin_drive_t PA_PIN, PB_PIN, PD_PIN, PG_PIN, PAN_PIN, PK_PIN;
  port_cfg_t PA_CFG, PB_CFG, PD_CFG, PG_CFG, PAN_CFG, PK_CFG;
  logic [1:0] PA_RTO_EN, PD_OD_EN, PK_OD_EN;
  bus_ctl_fn_t PG_FN;
  logic IOP_CSI1_OUT, IOP_CSI1_OE, STROBE_CLK_PIN, PB_UART_B_EN, PB_CSI2_EN;
  logic IOP_PULL_EN, CSI_ONE_MODE_REG, PD_CSI0_EN, PK_CSI3_EN, STROBE_SEL_CLK;
  logic CSI1_CLK_OUT, CSI1_CLK_MASTER, CSI0_CLK_OUT, CSI0_DATA_OUT;
  logic CSI3_CLK_OUT, CSI3_DATA_OUT, CSI2_CLK_OUT, CSI2_CLK_MASTER;
  logic CSI2_DATA_OUT, UART_B_TX, BUS_HOLD_ACK, REFRESH_PULSE_OUT;
  logic ADDR_LATCH_STROBE, CLOCK_OUT_PIN, NMI_REQ, EXT_IRQ_IN_A, TC1_COUNT_CLK;
  logic TC1_CAPCMP_A_TRIG, TC1_CAPCMP_B_TRIG, EXT_IRQ_IN_F, AD_START_TRIG;
  logic CSI_ONE_CLOCK_IN, UART_B_RX, UART_B_BAUD_CLK, CSI2_DATA_IN;
  logic CSI2_CLK_IN, BUS_HOLD_REQ, WAIT_REQ;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  port_pin_function_mux dut (.*);
  pad_world wa (.p(PA_PIN), .ext(xt[0]), .ext_en(xe[0]), .lvl(PA_IN));
  pad_world wb (.p(PB_PIN), .ext(xt[1]), .ext_en(xe[1]), .lvl(PB_IN));
  pad_world wd (.p(PD_PIN), .ext(xt[2]), .ext_en(xe[2]), .lvl(PD_IN));
  pad_world wg (.p(PG_PIN), .ext(xt[3]), .ext_en(xe[3]), .lvl(PG_IN));
  pad_world wn (.p(PAN_PIN), .ext(xt[4]), .ext_en(xe[4]), .lvl(PAN_IN));
  pad_world wk (.p(PK_PIN), .ext(xt[5]), .ext_en(xe[5]), .lvl(PK_IN));
  always #25 CORE_CLK = ~CORE_CLK;
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : step
  task automatic t_pa();
    PA_CFG = {8'hA5, 8'h0F, 1'b1};
    xe[0] = 8'h0F;
    xt[0] = 8'h06;
    step(2);
    chk("pa_oe", PA_PIN.oe, 8'hF0);
    chk("pa_pull", PA_PIN.pull, 8'h0F);
    chk("pa_rd", PA_RD, 8'hA6);
    xe[0] = 8'h00;
    PA_RTO_EN = 2'h1;
    PA_RTO_DATA = 8'h3C;
    step(1);
    chk("pa_rto", {PA_PIN.oe[3:0], PA_PIN.dout[7:4]}, 8'hFA);
    chk("pa_rto_lo", PA_PIN.dout[3:0], 8'h0C);
    PA_RTO_EN = 2'h0;
    $display("port a test done");
  endtask : t_pa
  task automatic t_iop();
    IOP_IN = 8'h43;
    IOP_PULL_EN = 1'b1;
    step(2);
    chk("iop_pull", IOP_PULL, 8'hFC);
    chk("iop_rd", IOP_RD, 8'h43);
    chk("nmi", NMI_REQ, 8'h01);
    chk("tc1", {EXT_IRQ_IN_A, TC1_COUNT_CLK, TC1_CAPCMP_A_TRIG,
      TC1_CAPCMP_B_TRIG}, 8'h0F);
    chk("ad_trig", {EXT_IRQ_IN_F, AD_START_TRIG}, 8'h03);
    CSI_ONE_MODE_REG = 1'b1;
    CSI1_CLK_MASTER = 1'b1;
    CSI1_CLK_OUT = 1'b1;
    step(1);
    chk("csi1_drv", {IOP_CSI1_OE, IOP_CSI1_OUT}, 8'h03);
    chk("csi1_pull", IOP_PULL, 8'hDC);
    CSI1_CLK_MASTER = 1'b0;
    IOP_IN = 8'h20;
    step(2);
    chk("csi1_in", {CSI_ONE_CLOCK_IN, NMI_REQ}, 8'h02);
    $display("input port test done");
  endtask : t_iop
  task automatic t_od();
    PD_OD_EN = 2'h3;
    PD_CSI0_EN = 1'b1;
    CSI0_CLK_OUT = 1'b1;
    PK_OD_EN = 2'h3;
    PK_CSI3_EN = 1'b1;
    CSI3_DATA_OUT = 1'b0;
    step(1);
    chk("pd_od", {PD_PIN.oe[3:2], PD_PIN.dout[3]}, 8'h04);
    chk("pk_od", {PK_PIN.oe[7], PK_PIN.dout[7]}, 8'h02);
    CSI0_CLK_OUT = 1'b0;
    CSI3_DATA_OUT = 1'b1;
    step(1);
    chk("pd_od_lo", {PD_PIN.oe[2], PD_PIN.dout[2]}, 8'h02);
    chk("pk_od_off", PK_PIN.oe[7], 8'h00);
    PD_OD_EN = 2'h0;
    CSI0_CLK_OUT = 1'b1;
    step(1);
    chk("pd_push", {PD_PIN.oe[2], PD_PIN.dout[2]}, 8'h03);
    $display("open drain test done");
  endtask : t_od
  task automatic t_alt();
    PAN_CFG = {8'h00, 8'hFF, 1'b0};
    xe[4] = 8'hFF;
    xt[4] = 8'h5A;
    PB_CFG = {8'h00, 8'h0C, 1'b0};
    PB_UART_B_EN = 1'b1;
    UART_B_TX = 1'b1;
    xe[1] = 8'h0C;
    xt[1] = 8'h0C;
    PG_CFG = {8'h00, 8'h40, 1'b0};
    PG_FN = P7_FN_HOLD;
    BUS_HOLD_ACK = 1'b1;
    xe[3] = 8'h40;
    xt[3] = 8'h40;
    step(2);
    chk("an_in", ANALOG_INPUTS, 8'h5A);
    chk("an_rd", PAN_RD, 8'h5A);
    chk("uart_b", {PB_PIN.oe[4], PB_PIN.dout[4], UART_B_RX,
      UART_B_BAUD_CLK}, 8'h0F);
    chk("hold", {BUS_HOLD_REQ, PG_PIN.oe[7], PG_PIN.dout[7]}, 8'h07);
    PG_FN = P7_FN_WAIT;
    REFRESH_PULSE_OUT = 1'b1;
    BUS_HOLD_ACK = 1'b0;
    PAN_CFG = {8'hC3, 8'h0F, 1'b0};
    step(2);
    chk("wait", {WAIT_REQ, BUS_HOLD_REQ, PG_PIN.dout[7]}, 8'h05);
    chk("an_oe", PAN_PIN.oe, 8'hF0);
    for (int s = 0; s < 4; s++) begin
      STROBE_SEL_CLK = s[0];
      ADDR_LATCH_STROBE = s[1];
      CLOCK_OUT_PIN = ~s[1];
      step(1);
      chk("strobe", STROBE_CLK_PIN, {7'h00, s[0] ^ s[1]});
    end
    $display("shared pin test done");
  endtask : t_alt
  task automatic t_csi2();
    PB_CFG = {8'h00, 8'h18, 1'b1};
    PB_CSI2_EN = 1'b1;
    CSI2_CLK_MASTER = 1'b1;
    CSI2_CLK_OUT = 1'b1;
    CSI2_DATA_OUT = 1'b0;
    xe[1] = 8'h08;
    xt[1] = 8'h08;
    step(2);
    chk("csi2_out", {PB_PIN.oe[4:2], PB_PIN.dout[4], PB_PIN.dout[2]},
      8'h15);
    chk("pb_pull", PB_PIN.pull, 8'h08);
    chk("csi2_in", {CSI2_DATA_IN, CSI2_CLK_IN}, 8'h03);
    chk("pb_rd", PB_RD, 8'h0C);
    chk("pd_rd", PD_RD, 8'h04);
    chk("pg_rd", PG_RD, 8'hC0);
    chk("pk_rd", PK_RD, 8'h80);
    $display("serial two and read-back test done");
  endtask : t_csi2
  initial begin
    {PA_CFG, PB_CFG, PD_CFG, PG_CFG, PAN_CFG, PK_CFG, PA_RTO_EN, PD_OD_EN,
      PK_OD_EN, PA_RTO_DATA, PB_UART_B_EN, PB_CSI2_EN, IOP_PULL_EN,
      CSI_ONE_MODE_REG, PD_CSI0_EN, PK_CSI3_EN, STROBE_SEL_CLK, CSI1_CLK_OUT,
      CSI1_CLK_MASTER, CSI0_CLK_OUT, CSI0_DATA_OUT, CSI3_CLK_OUT,
      CSI3_DATA_OUT, CSI2_CLK_OUT, CSI2_CLK_MASTER, CSI2_DATA_OUT, UART_B_TX,
      BUS_HOLD_ACK, REFRESH_PULSE_OUT, ADDR_LATCH_STROBE,
      CLOCK_OUT_PIN} = '0;
    PG_FN = P7_FN_PORT;
    xt = '{default: 8'h00};
    xe = '{default: 8'h00};
    IOP_IN = 8'hFF;
    step(16);
    chk("rd_rst", IOP_RD, 8'h00);
    RST_N = 1'b1;
    step(3);
    chk("pull_off", IOP_PULL, 8'h00);
    t_pa();
    t_iop();
    t_od();
    t_alt();
    t_csi2();
    test_done();
  end
endmodule : tb
`default_nettype wire
